/* File: iov_map.svh */
// address map, field masks, reset values and vector addresses
`ifndef IOV_MAP_SVH
`define IOV_MAP_SVH

`define IOV_ADDR_STAT       6'h3f
`define IOV_ADDR_GMASK      6'h3b
`define IOV_ADDR_GFLAG      6'h3a
`define IOV_ADDR_TMASK      6'h39
`define IOV_ADDR_TFLAG      6'h38
`define IOV_BIT_IO_LIMIT    6'h20

`define IOV_STAT_GIE        7
`define IOV_STAT_STORE      6
`define IOV_STAT_HALF       5
`define IOV_STAT_SIGN       4
`define IOV_STAT_OVF        3
`define IOV_STAT_NEG        2
`define IOV_STAT_ZERO       1
`define IOV_STAT_CARRY      0
`define IOV_ALU_FLAG_MASK   8'h2f

`define IOV_GIRQ_EXT0_M     8'h40
`define IOV_GIRQ_PCHG_M     8'h20
`define IOV_TIRQ_T1CMP_M    8'h40
`define IOV_TIRQ_T1OVF_M    8'h04
`define IOV_TIRQ_T0OVF_M    8'h02
`define IOV_GFLAG_IMPL_M    8'h60
`define IOV_TFLAG_IMPL_M    8'h46

`define IOV_RST_BYTE        8'h00
`define IOV_VEC_RESET       9'h000
`define IOV_VEC_FIRST_IRQ   9'h001
`define IOV_VEC_LAST        9'h008

`endif

/* File: iov_pkg.sv */
// shared types for the io space and interrupt vectoring core
package iov_pkg;

    typedef enum logic [3:0] {
        IOV_OP_NOP      = 4'h0,
        IOV_OP_IO_IN    = 4'h1,
        IOV_OP_IO_OUT   = 4'h2,
        IOV_OP_SET_BIT  = 4'h3,
        IOV_OP_CLR_BIT  = 4'h4,
        IOV_OP_SKIP_SET = 4'h5,
        IOV_OP_SKIP_CLR = 4'h6,
        IOV_OP_BIT_STO  = 4'h7,
        IOV_OP_BIT_LOAD = 4'h8,
        IOV_OP_RET      = 4'h9,
        IOV_OP_LOAD_IMM = 4'ha,
        IOV_OP_ALU_FLG  = 4'hb,
        IOV_OP_READ_REG = 4'hc
    } iov_op_t;

endpackage

/* File: iov_prio_enc.sv */
// fixed priority picker, lowest index wins
`timescale 1ns/1ps
module iov_prio_enc (
    input  wire logic [7:0] req,
    output logic            any,
    output logic [7:0]      onehot,
    output logic [2:0]      idx
);
    always_comb begin
        any    = 1'b0;
        onehot = 8'h00;
        idx    = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                any    = 1'b1;
                onehot = 8'h01 << i;
                idx    = 3'(i);
            end
        end
    end
endmodule // iov_prio_enc

/* File: iov_io_irq_core.sv */
// io space decode, status register and interrupt vectoring core
`timescale 1ns/1ps
`include "iov_map.svh"
module iov_io_irq_core (
    input  wire logic            clk_sys,
    input  wire logic            arst_n,
    input  wire logic            clk_en,
    input  wire logic            cmd_valid,
    input  wire iov_pkg::iov_op_t cmd_op,
    input  wire logic [4:0]      cmd_reg,
    input  wire logic [5:0]      cmd_io_addr,
    input  wire logic [2:0]      cmd_bit,
    input  wire logic [7:0]      cmd_imm,
    output logic                 cmd_done,
    output logic                 skip_next,
    output logic [7:0]           rd_data,
    output logic [5:0]           per_addr,
    output logic                 per_rd_en,
    output logic                 per_wr_en,
    output logic [7:0]           per_wr_data,
    input  wire logic [7:0]      per_rd_data,
    input  wire logic            ev_ext_req0,
    input  wire logic            ev_pin_change,
    input  wire logic            ev_t1_compare,
    input  wire logic            ev_t1_overflow,
    input  wire logic            ev_t0_overflow,
    input  wire logic            req_eeprom_done,
    input  wire logic            req_comparator,
    input  wire logic            req_adc_done,
    input  wire logic            irq_ack_ready,
    output logic                 vec_valid,
    output logic [8:0]           vec_addr,
    output logic [7:0]           status_flags
);
    logic       rst_meta_reg;
    logic       rst_n;
    logic [7:0] stat_reg;
    logic [7:0] gmask_reg;
    logic [7:0] gflag_reg;
    logic [7:0] tmask_reg;
    logic [7:0] tflag_reg;
    logic       start_pend_reg;
    logic       cmd_done_reg;
    logic       skip_reg;
    logic [7:0] rd_data_reg;
    logic       vec_valid_reg;
    logic [8:0] vec_addr_reg;
    logic [7:0] rf_mem [0:31];

    // two-stage release of the asynchronous reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // command decode
    wire cmd_take = clk_en & cmd_valid;
    wire is_in    = cmd_take & (cmd_op == iov_pkg::IOV_OP_IO_IN);
    wire is_out   = cmd_take & (cmd_op == iov_pkg::IOV_OP_IO_OUT);
    wire is_sbit  = cmd_take & (cmd_op == iov_pkg::IOV_OP_SET_BIT);
    wire is_cbit  = cmd_take & (cmd_op == iov_pkg::IOV_OP_CLR_BIT);
    wire is_sks   = cmd_take & (cmd_op == iov_pkg::IOV_OP_SKIP_SET);
    wire is_skc   = cmd_take & (cmd_op == iov_pkg::IOV_OP_SKIP_CLR);
    wire is_tcopy = cmd_take & (cmd_op == iov_pkg::IOV_OP_BIT_STO);
    wire is_tload = cmd_take & (cmd_op == iov_pkg::IOV_OP_BIT_LOAD);
    wire is_ret   = cmd_take & (cmd_op == iov_pkg::IOV_OP_RET);
    wire is_ldi   = cmd_take & (cmd_op == iov_pkg::IOV_OP_LOAD_IMM);
    wire is_alu   = cmd_take & (cmd_op == iov_pkg::IOV_OP_ALU_FLG);
    wire is_rreg  = cmd_take & (cmd_op == iov_pkg::IOV_OP_READ_REG);

    // io address decode
    wire a_stat  = (cmd_io_addr == `IOV_ADDR_STAT);
    wire a_gmask = (cmd_io_addr == `IOV_ADDR_GMASK);
    wire a_gflag = (cmd_io_addr == `IOV_ADDR_GFLAG);
    wire a_tmask = (cmd_io_addr == `IOV_ADDR_TMASK);
    wire a_tflag = (cmd_io_addr == `IOV_ADDR_TFLAG);
    wire a_local = a_stat | a_gmask | a_gflag | a_tmask | a_tflag;
    wire a_low   = (cmd_io_addr < `IOV_BIT_IO_LIMIT);

    wire [7:0] rf_rd    = rf_mem[cmd_reg];
    wire [7:0] bit_mask = 8'h01 << cmd_bit;
    wire       rf_bit   = rf_rd[cmd_bit];
    wire       per_bit  = per_rd_data[cmd_bit];

    // sign bit is rebuilt on every view of the status byte
    wire sign_now = stat_reg[`IOV_STAT_NEG] ^ stat_reg[`IOV_STAT_OVF];
    wire [7:0] stat_view = {stat_reg[7:5], sign_now,
                            stat_reg[3:0]};

    wire [7:0] local_rd;
    assign local_rd = a_stat  ? stat_view :
                      a_gmask ? gmask_reg :
                      a_gflag ? gflag_reg :
                      a_tmask ? tmask_reg : tflag_reg;
    wire [7:0] io_rd_byte = a_local ? local_rd : per_rd_data;

    // peripheral side; bit ops are a same-cycle read-modify-write
    wire bit_op = (is_sbit | is_cbit) & a_low;
    wire sk_op  = (is_sks | is_skc) & a_low;
    wire [7:0] rmw_byte = is_sbit ? (per_rd_data | bit_mask)
                                  : (per_rd_data & ~bit_mask);
    assign per_addr    = cmd_io_addr;
    assign per_rd_en   = (is_in & ~a_local) | bit_op | sk_op;
    assign per_wr_en   = (is_out & ~a_local) | bit_op;
    assign per_wr_data = bit_op ? rmw_byte : rf_rd;

    // working register file: no reset, it survives every reset
    wire [7:0] rf_tload = (rf_rd & ~bit_mask)
                        | ({8{stat_reg[`IOV_STAT_STORE]}} & bit_mask);
    wire       rf_we  = is_in | is_tload | is_ldi;
    wire [7:0] rf_wdata = is_in    ? io_rd_byte :
                          is_tload ? rf_tload : cmd_imm;
    always_ff @(posedge clk_sys) begin
        if (clk_en && rf_we) begin
            rf_mem[cmd_reg] <= rf_wdata;
        end
    end

    // interrupt requests in vector order, lowest index first
    wire [7:0] irq_req;
    assign irq_req[0] = |(gflag_reg & gmask_reg & `IOV_GIRQ_EXT0_M);
    assign irq_req[1] = |(gflag_reg & gmask_reg & `IOV_GIRQ_PCHG_M);
    assign irq_req[2] = |(tflag_reg & tmask_reg & `IOV_TIRQ_T1CMP_M);
    assign irq_req[3] = |(tflag_reg & tmask_reg & `IOV_TIRQ_T1OVF_M);
    assign irq_req[4] = |(tflag_reg & tmask_reg & `IOV_TIRQ_T0OVF_M);
    // the last three carry their enables in their own peripherals
    assign irq_req[5] = req_eeprom_done;
    assign irq_req[6] = req_comparator;
    assign irq_req[7] = req_adc_done;

    logic       irq_any;
    logic [7:0] irq_sel;
    logic [2:0] irq_idx;
    iov_prio_enc u_prio (
        .req    (irq_req),
        .any    (irq_any),
        .onehot (irq_sel),
        .idx    (irq_idx)
    );

    // one accept at an instruction boundary, never beside a command
    wire irq_take = clk_en & stat_reg[`IOV_STAT_GIE] & irq_any
                  & irq_ack_ready & ~cmd_valid & ~start_pend_reg;
    wire [8:0] irq_vec = `IOV_VEC_FIRST_IRQ + {6'h00, irq_idx};

    // status register next value
    wire       stat_wr   = is_out & a_stat;
    wire [7:0] stat_base = stat_wr ? rf_rd : stat_reg;
    wire [7:0] stat_alu  = is_alu ? ((stat_base & ~`IOV_ALU_FLAG_MASK)
                         | (cmd_imm & `IOV_ALU_FLAG_MASK))
                         : stat_base;
    wire t_new = is_tcopy ? rf_bit : stat_alu[`IOV_STAT_STORE];
    wire i_new = irq_take ? 1'b0 :
                 is_ret   ? 1'b1 : stat_alu[`IOV_STAT_GIE];
    wire [7:0] stat_next = {i_new, t_new, stat_alu[`IOV_STAT_HALF], 1'b0,
                            stat_alu[3:0]};

    // flags: write one to clear, accept clears its own flag, set wins
    wire [7:0] g_set = ({8{ev_ext_req0}}   & `IOV_GIRQ_EXT0_M)
                     | ({8{ev_pin_change}} & `IOV_GIRQ_PCHG_M);
    wire [7:0] t_set = ({8{ev_t1_compare}}  & `IOV_TIRQ_T1CMP_M)
                     | ({8{ev_t1_overflow}} & `IOV_TIRQ_T1OVF_M)
                     | ({8{ev_t0_overflow}} & `IOV_TIRQ_T0OVF_M);
    wire [7:0] g_acc = {8{irq_take}} & (({8{irq_sel[0]}} & `IOV_GIRQ_EXT0_M)
                     | ({8{irq_sel[1]}} & `IOV_GIRQ_PCHG_M));
    wire [7:0] t_acc = {8{irq_take}} & (({8{irq_sel[2]}} & `IOV_TIRQ_T1CMP_M)
                     | ({8{irq_sel[3]}} & `IOV_TIRQ_T1OVF_M)
                     | ({8{irq_sel[4]}} & `IOV_TIRQ_T0OVF_M));
    wire [7:0] g_clr = ({8{is_out & a_gflag}} & rf_rd) | g_acc;
    wire [7:0] t_clr = ({8{is_out & a_tflag}} & rf_rd) | t_acc;
    wire [7:0] gflag_next = ((gflag_reg & ~g_clr) | g_set) & `IOV_GFLAG_IMPL_M;
    wire [7:0] tflag_next = ((tflag_reg & ~t_clr) | t_set) & `IOV_TFLAG_IMPL_M;

    wire [7:0] rd_next  = is_rreg ? rf_rd : io_rd_byte;
    wire       skip_val = sk_op & (is_sks ? per_bit : ~per_bit);
    wire [8:0] vec_next = start_pend_reg ? `IOV_VEC_RESET : irq_vec;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg       <= `IOV_RST_BYTE;
            gmask_reg      <= `IOV_RST_BYTE;
            gflag_reg      <= `IOV_RST_BYTE;
            tmask_reg      <= `IOV_RST_BYTE;
            tflag_reg      <= `IOV_RST_BYTE;
            start_pend_reg <= 1'b1;
            cmd_done_reg   <= 1'b0;
            skip_reg       <= 1'b0;
            rd_data_reg    <= `IOV_RST_BYTE;
            vec_valid_reg  <= 1'b0;
            vec_addr_reg   <= `IOV_VEC_RESET;
        end else if (clk_en) begin
            stat_reg       <= stat_next;
            gflag_reg      <= gflag_next;
            tflag_reg      <= tflag_next;
            gmask_reg      <= (is_out & a_gmask) ? rf_rd : gmask_reg;
            tmask_reg      <= (is_out & a_tmask) ? rf_rd : tmask_reg;
            start_pend_reg <= 1'b0;
            cmd_done_reg   <= cmd_valid;
            skip_reg       <= cmd_valid ? skip_val : skip_reg;
            rd_data_reg    <= (is_in | is_rreg) ? rd_next : rd_data_reg;
            vec_valid_reg  <= start_pend_reg | irq_take;
            vec_addr_reg   <= (start_pend_reg | irq_take) ? vec_next
                                                          : vec_addr_reg;
        end else begin
            cmd_done_reg  <= 1'b0;
            vec_valid_reg <= 1'b0;
        end
    end

    assign cmd_done     = cmd_done_reg;
    assign skip_next    = skip_reg;
    assign rd_data      = rd_data_reg;
    assign vec_valid    = vec_valid_reg;
    assign vec_addr     = vec_addr_reg;
    assign status_flags = stat_view;

    // checks
    gie_blocks_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !stat_reg[`IOV_STAT_GIE] |-> !irq_take)
        else $error("interrupt taken with global enable clear");

    take_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_take |=> !stat_reg[`IOV_STAT_GIE] && vec_valid)
        else $error("accept did not clear global enable");

    ret_sets_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_ret |=> stat_reg[`IOV_STAT_GIE])
        else $error("return did not set global enable");

    sign_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_in && a_stat |=>
            rd_data[4] == (rd_data[3] ^ rd_data[2]))
        else $error("sign bit differs from negative xor overflow");

    own_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_take && irq_sel[0] |-> |(gmask_reg & `IOV_GIRQ_EXT0_M))
        else $error("source taken without its enable");

    prio_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_take && irq_req[0] |=> vec_addr == `IOV_VEC_FIRST_IRQ)
        else $error("highest priority request not vectored");

    vec_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        vec_valid |-> vec_addr <= `IOV_VEC_LAST)
        else $error("vector outside table");

    reset_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_pend_reg && clk_en |=> vec_valid
            && vec_addr == `IOV_VEC_RESET
            && stat_reg == `IOV_RST_BYTE)
        else $error("reset did not vector to zero");

    others_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_take && irq_req[0] && irq_req[1] |=>
            |(gflag_reg & `IOV_GIRQ_PCHG_M))
        else $error("lower priority request was lost");

    bit_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bit_op |-> per_wr_data[cmd_bit] == is_sbit
            && ((per_wr_data ^ per_rd_data) & ~bit_mask) == 8'h00)
        else $error("bit operation disturbed other bits");

    skip_test_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_sks && a_low |=> skip_next == $past(per_bit))
        else $error("skip result does not follow tested bit");

    store_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_tcopy |=> stat_reg[`IOV_STAT_STORE] == $past(rf_bit))
        else $error("store bit not copied");

    alu_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_alu && !stat_wr |=> (stat_reg & `IOV_ALU_FLAG_MASK)
            == ($past(cmd_imm) & `IOV_ALU_FLAG_MASK))
        else $error("alu flags not updated");

    mask_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_out && a_gmask |=> gmask_reg == $past(rf_rd))
        else $error("mask register write lost");
endmodule // iov_io_irq_core

/* File: iov_periph_model.sv */
// peripheral register model standing behind the io port of the core
`timescale 1ns/1ps
module iov_periph_model (
    input  wire logic       clk_sys,
    input  wire logic [5:0] per_addr,
    input  wire logic       per_rd_en,
    input  wire logic       per_wr_en,
    input  wire logic [7:0] per_wr_data,
    output logic      [7:0] per_rd_data
);
    logic [7:0] mem [64];
    logic [7:0] last_reg;

    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        last_reg = 8'h00;
    end
    always @(posedge clk_sys) begin
        if (per_wr_en) mem[per_addr] <= per_wr_data;
        if (per_rd_en) last_reg <= mem[per_addr];
    end
    // unselected port shows the inverse of the last byte, never a stale copy
    assign per_rd_data = per_rd_en ? mem[per_addr] : ~last_reg;
endmodule // iov_periph_model

/* File: io_space_status_and_irq_vectors_test.sv */
// self-checking bench for the io space and interrupt vectoring core
`timescale 1ns/1ps
module io_space_status_and_irq_vectors_test;
    logic             clk_sys, arst_n, clk_en, cmd_valid, irq_ack_ready;
    iov_pkg::iov_op_t cmd_op;
    logic [4:0]       cmd_reg;
    logic [5:0]       cmd_io_addr, per_addr, a;
    logic [2:0]       cmd_bit, b;
    logic [7:0]       cmd_imm, rd_data, per_wr_data, per_rd_data, v, e;
    logic [7:0]       status_flags, src;
    logic             cmd_done, skip_next, per_rd_en, per_wr_en, vec_valid;
    logic [8:0]       vec_addr;
    logic [3:0]       op;
    int               fails, n_compared;
    // rows: io address, byte written, byte read back
    localparam logic [21:0] ROWS [6] = '{{6'h3f, 8'ha5, 8'hb5},
        {6'h3f, 8'h08, 8'h18}, {6'h3f, 8'h00, 8'h00}, {6'h3b, 8'h60, 8'h60},
        {6'h39, 8'h46, 8'h46}, {6'h18, 8'h5a, 8'h5a}};
    // rows: alu flag input, expected status view
    localparam logic [15:0] ALUS [4] = '{{8'h2f, 8'h2f}, {8'h04, 8'h14},
        {8'h08, 8'h18}, {8'h23, 8'h23}};
    // rows: op, address, bit, expected byte or skip decision
    localparam logic [20:0] BITS [8] = '{{4'h3, 6'h18, 3'd0, 8'h5b},
        {4'h4, 6'h18, 3'd6, 8'h1b}, {4'h3, 6'h39, 3'd0, 8'h46},
        {4'h5, 6'h18, 3'd0, 8'h01}, {4'h5, 6'h18, 3'd2, 8'h00},
        {4'h6, 6'h18, 3'd2, 8'h01}, {4'h6, 6'h18, 3'd3, 8'h00},
        {4'h5, 6'h39, 3'd2, 8'h00}};

    iov_io_irq_core u_iov_io_irq_core (
        .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_reg(cmd_reg),
        .cmd_io_addr(cmd_io_addr), .cmd_bit(cmd_bit), .cmd_imm(cmd_imm),
        .cmd_done(cmd_done), .skip_next(skip_next), .rd_data(rd_data),
        .per_addr(per_addr), .per_rd_en(per_rd_en), .per_wr_en(per_wr_en),
        .per_wr_data(per_wr_data), .per_rd_data(per_rd_data),
        .ev_ext_req0(src[0]), .ev_pin_change(src[1]),
        .ev_t1_compare(src[2]), .ev_t1_overflow(src[3]),
        .ev_t0_overflow(src[4]), .req_eeprom_done(src[5]),
        .req_comparator(src[6]), .req_adc_done(src[7]),
        .irq_ack_ready(irq_ack_ready), .vec_valid(vec_valid),
        .vec_addr(vec_addr), .status_flags(status_flags));

    iov_periph_model u_iov_periph_model (
        .clk_sys(clk_sys), .per_addr(per_addr), .per_rd_en(per_rd_en),
        .per_wr_en(per_wr_en), .per_wr_data(per_wr_data),
        .per_rd_data(per_rd_data));

    task automatic test_done();
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic chkv(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t vector %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [3:0] o, input logic [4:0] r,
                       input logic [5:0] ad, input logic [2:0] bt,
                       input logic [7:0] im);
        int k;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op <= iov_pkg::iov_op_t'(o);
        cmd_reg <= r;
        cmd_io_addr <= ad;
        cmd_bit <= bt;
        cmd_imm <= im;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        #1;
        k = 0;
        while (cmd_done !== 1'b1 && k < 4) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k == 4) begin
            fails++;
            $display("[ERR] %0t command not done", $time);
            test_done();
        end
    endtask
    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        cmd(4'ha, 5'd1, 6'h00, 3'd0, d);
        cmd(4'h2, 5'd1, ad, 3'd0, 8'h00);
    endtask
    task automatic rd(input logic [5:0] ad, input logic [7:0] exp);
        cmd(4'h1, 5'd2, ad, 3'd0, 8'h00);
        chk8(rd_data, exp);
    endtask
    task automatic expect_vec(input logic [8:0] exp);
        int k;
        k = 0;
        while (vec_valid !== 1'b1 && k < 8) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k == 8) begin
            fails++;
            $display("[ERR] %0t no vector", $time);
            test_done();
        end
        chkv(vec_addr, exp);
        chk1(status_flags[7], 1'b0);
    endtask
    task automatic no_vec();
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            chk1(vec_valid, 1'b0);
        end
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_sys);
        src <= m;
        @(posedge clk_sys);
        src <= 8'h00;
        #1;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {arst_n, cmd_valid, cmd_reg, cmd_io_addr, cmd_bit, cmd_imm} = '0;
        cmd_op = iov_pkg::IOV_OP_NOP;
        clk_en = 1'b1;
        irq_ack_ready = 1'b1;
        src = 8'h00;
        fails = 0;
        n_compared = 0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        expect_vec(9'h000);
        chk8(status_flags, 8'h00);
        foreach (ROWS[i]) begin
            {a, v, e} = ROWS[i];
            wr(a, v);
            rd(a, e);
            if (a == 6'h3f) chk8(status_flags, e);
        end
        foreach (ALUS[i]) begin
            cmd(4'hb, 5'd0, 6'h00, 3'd0, ALUS[i][15:8]);
            chk8(status_flags, ALUS[i][7:0]);
        end
        cmd(4'hb, 5'd0, 6'h00, 3'd0, 8'h00);
        foreach (BITS[i]) begin
            {op, a, b, e} = BITS[i];
            cmd(op, 5'd0, a, b, 8'h00);
            if (op >= 4'h5) chk1(skip_next, e[0]);
            else rd(a, e);
        end
        cmd(4'ha, 5'd3, 6'h00, 3'd0, 8'h10);
        cmd(4'h7, 5'd3, 6'h00, 3'd4, 8'h00);
        chk1(status_flags[6], 1'b1);
        cmd(4'ha, 5'd4, 6'h00, 3'd0, 8'h00);
        cmd(4'h8, 5'd4, 6'h00, 3'd7, 8'h00);
        cmd(4'hc, 5'd4, 6'h00, 3'd0, 8'h00);
        chk8(rd_data, 8'h80);
        cmd(4'h7, 5'd4, 6'h00, 3'd0, 8'h00);
        chk1(status_flags[6], 1'b0);
        pulse(8'h03);
        no_vec();
        rd(6'h3a, 8'h60);
        wr(6'h3f, 8'h80);
        expect_vec(9'h001);
        rd(6'h3a, 8'h20);
        cmd(4'h9, 5'd0, 6'h00, 3'd0, 8'h00);
        expect_vec(9'h002);
        cmd(4'h9, 5'd0, 6'h00, 3'd0, 8'h00);
        pulse(8'h1c);
        for (int n = 3; n <= 5; n++) begin
            expect_vec(9'(n));
            cmd(4'h9, 5'd0, 6'h00, 3'd0, 8'h00);
        end
        @(posedge clk_sys);
        src <= 8'he0;
        for (int n = 6; n <= 8; n++) begin
            expect_vec(9'(n));
            @(posedge clk_sys);
            src[n - 1] <= 1'b0;
            cmd(4'h9, 5'd0, 6'h00, 3'd0, 8'h00);
        end
        wr(6'h3b, 8'h00);
        pulse(8'h01);
        no_vec();
        rd(6'h3a, 8'h40);
        @(posedge clk_sys);
        irq_ack_ready <= 1'b0;
        wr(6'h3b, 8'h40);
        no_vec();
        @(posedge clk_sys);
        irq_ack_ready <= 1'b1;
        expect_vec(9'h001);
        rd(6'h3a, 8'h00);
        cmd(4'ha, 5'd5, 6'h00, 3'd0, 8'h3c);
        // a command offered with the clock enable low must be ignored
        @(posedge clk_sys);
        clk_en <= 1'b0;
        cmd_valid <= 1'b1;
        cmd_op <= iov_pkg::IOV_OP_LOAD_IMM;
        cmd_reg <= 5'd5;
        cmd_imm <= 8'hff;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        clk_en <= 1'b1;
        #1;
        chk1(cmd_done, 1'b0);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        expect_vec(9'h000);
        chk8(status_flags, 8'h00);
        rd(6'h3b, 8'h00);
        cmd(4'hc, 5'd5, 6'h00, 3'd0, 8'h00);
        chk8(rd_data, 8'h3c);
        test_done();
    end
endmodule // io_space_status_and_irq_vectors_test
